// [src/rtc_cal_defs.vh]
// Constants for the one-second tick generator and its daily calibration.
// Assumes inclusion by bare name from the design files under src/.
`ifndef RTC_CAL_DEFS_VH
`define RTC_CAL_DEFS_VH

// ==========================================================
// Register indexes (byte address is four times the index)
`define IDX_SECONDS 16'h9100
`define IDX_MINUTES 16'h9101
`define IDX_HOURS 16'h9102
`define IDX_DIV_BYTE0 16'h9130
`define IDX_DIV_BYTE1 16'h9131
`define IDX_DIV_BYTE2 16'h9132
`define IDX_DAILY_RATE_TRIM 16'h9133
`define IDX_CAL_STATUS 16'h9134
`define ADDR_W 20

// ==========================================================
// Reset values and field layout
`define DIV_RESET 24'h0aec85
`define TRIM_RESET 8'h00
`define TRIM_CODE_W 5
`define STAT_PHASE_BIT 0
`define STAT_SKIP_BIT 1
`define STAT_ADD_BIT 2

// ==========================================================
// Timing counts
`define PRESCALE_DIV 5
`define CORR_HOURS 5'h00
`define CORR_MINUTES 6'h00
`define CORR_SECONDS 6'h1e

`endif

// [src/second_divider.v]
// Prescaler and programmable divider that turn the crystal into one tick a second.
// Assumes xtal_in is a crystal-rate square wave well below half the hclk rate.
`timescale 1ns/1ps
`include "rtc_cal_defs.vh"

module second_divider #(
	parameter PRESCALE = `PRESCALE_DIV,
	parameter DIV_W = 24
) (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire xtal_in,
	input wire [DIV_W-1:0] div_value,
	output reg tick
);
	// ==========================================================
	// Pin synchroniser and edge detect
	reg xtal_meta;
	reg xtal_sync;
	reg xtal_last;
	reg [2:0] pre_cnt;
	reg [DIV_W-1:0] div_cnt;
	wire xtal_rise;
	wire pre_done;
	wire [DIV_W-1:0] div_last;

	assign xtal_rise = xtal_sync & ~xtal_last;
	assign pre_done = xtal_rise && (pre_cnt == PRESCALE[2:0] - 3'h1);
	// A zero divider would wrap to an all-ones terminal count; treat it as divide by one
	assign div_last = (div_value == {DIV_W{1'b0}}) ? {DIV_W{1'b0}} :
		div_value - {{(DIV_W-1){1'b0}}, 1'b1};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xtal_meta <= 1'b0;
			xtal_sync <= 1'b0;
			xtal_last <= 1'b0;
			pre_cnt <= 3'h0;
			div_cnt <= {DIV_W{1'b0}};
			tick <= 1'b0;
		end else if (ce) begin
			xtal_meta <= xtal_in;
			xtal_sync <= xtal_meta;
			xtal_last <= xtal_sync;
			tick <= 1'b0;
			if (xtal_rise) begin
				// Fixed divide by five ahead of the programmable stage
				if (pre_done)
					pre_cnt <= 3'h0;
				else
					pre_cnt <= pre_cnt + 3'h1;
			end
			if (pre_done) begin
				// Terminal count of the programmable stage gives the tick
				if (div_cnt >= div_last) begin
					div_cnt <= {DIV_W{1'b0}};
					tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// [src/rtc_one_hz_calibration.v]
// One-second tick generation, time-of-day count and daily seconds trim, with an
// AHB-Lite register slave. Assumes a single master with this slave alone on hready.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rtc_cal_defs.vh"

// What this block does
// - Crystal divided by five, then programmable divider
// - Divider resets to 715909 for one hertz
// - Divider value is three bytes, byte 0 lowest
// - Only trim bits 4:0 act on correction
// - Trim code is signed steps of 5.8 ppm
// - Day one floor, day two ceil of half
// - Day one and day two amounts alternate forever
// - Correction applied only at 00:00:30
// - Negative correction discards that many ticks
module rtc_one_hz_calibration #(
	parameter DIV_W = 24,
	parameter [DIV_W-1:0] DIV_DEFAULT = `DIV_RESET
) (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire xtal_in,
	input wire hsel,
	input wire [`ADDR_W-1:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	output reg second_tick,
	output reg [5:0] seconds,
	output reg [5:0] minutes,
	output reg [4:0] hours
);
	// ==========================================================
	// Helper functions
	function [16:0] next_time;
		input [16:0] now;
		reg [4:0] h;
		reg [5:0] m;
		reg [5:0] s;
		begin
			h = now[16:12];
			m = now[11:6];
			s = now[5:0];
			if (s >= 6'h3b) begin
				s = 6'h00;
				if (m >= 6'h3b) begin
					m = 6'h00;
					if (h >= 5'h17)
						h = 5'h00;
					else
						h = h + 5'h01;
				end else begin
					m = m + 6'h01;
				end
			end else begin
				s = s + 6'h01;
			end
			next_time = {h, m, s};
		end
	endfunction

	function [15:0] reg_index;
		input [`ADDR_W-1:0] a;
		begin
			reg_index = a[17:2];
		end
	endfunction

	// ==========================================================
	// Bus slave
	reg [DIV_W-1:0] div_value;
	reg [7:0] daily_rate_trim;
	reg day_phase;
	reg [3:0] skip_cnt;
	reg [3:0] add_pend;
	reg dp_write;
	reg [15:0] dp_index;
	wire addr_take;
	wire tick;
	wire [16:0] now_time;
	wire [16:0] inc_time;
	wire [4:0] trim_code;
	wire [4:0] trim_mag;
	wire [3:0] day_amount;
	wire corr_instant;
	wire wr_time;

	// Wait states only while the clock enable holds the block frozen
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign addr_take = ce && hready && hsel && htrans[1];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_index <= 16'h0000;
			hrdata <= 32'h00000000;
		end else if (ce) begin
			if (hready) begin
				dp_write <= addr_take && hwrite;
				dp_index <= reg_index(haddr);
			end
			if (addr_take && !hwrite) begin
				// Read data is sampled at the address phase, stable through the data phase
				case (reg_index(haddr))
				`IDX_SECONDS: hrdata <= {26'h0000000, seconds};
				`IDX_MINUTES: hrdata <= {26'h0000000, minutes};
				`IDX_HOURS: hrdata <= {27'h0000000, hours};
				`IDX_DIV_BYTE0: hrdata <= {24'h000000, div_value[7:0]};
				`IDX_DIV_BYTE1: hrdata <= {24'h000000, div_value[15:8]};
				`IDX_DIV_BYTE2: hrdata <= {24'h000000, div_value[23:16]};
				`IDX_DAILY_RATE_TRIM: hrdata <= {24'h000000, daily_rate_trim};
				`IDX_CAL_STATUS: hrdata <= {29'h00000000, add_pend != 4'h0,
					skip_cnt != 4'h0, day_phase};
				default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Divider and trim registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_value <= DIV_DEFAULT;
			daily_rate_trim <= `TRIM_RESET;
		end else if (ce && hready && dp_write) begin
			case (dp_index)
			`IDX_DIV_BYTE0: div_value[7:0] <= hwdata[7:0];
			`IDX_DIV_BYTE1: div_value[15:8] <= hwdata[7:0];
			`IDX_DIV_BYTE2: div_value[23:16] <= hwdata[7:0];
			`IDX_DAILY_RATE_TRIM: daily_rate_trim <= hwdata[7:0];
			default: ;
			endcase
		end
	end

	second_divider #(
		.PRESCALE(`PRESCALE_DIV),
		.DIV_W(DIV_W)
	) u_divider (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.xtal_in(xtal_in),
		.div_value(div_value),
		.tick(tick)
	);

	// ==========================================================
	// Daily correction amount
	// Upper trim bits are stored for readback but never reach the arithmetic
	assign trim_code = daily_rate_trim[`TRIM_CODE_W-1:0];
	// Two's-complement code, 5.8 ppm per step; magnitude reaches 16 for 10000
	assign trim_mag = trim_code[4] ? (5'h00 - trim_code) : trim_code;
	// Day one takes the floor of half, day two the ceiling
	assign day_amount = day_phase ? (trim_mag[4:1] + {3'h0, trim_mag[0]}) : trim_mag[4:1];

	assign now_time = {hours, minutes, seconds};
	assign inc_time = next_time(now_time);
	assign corr_instant = (inc_time == {`CORR_HOURS, `CORR_MINUTES, `CORR_SECONDS});
	assign wr_time = ce && hready && dp_write &&
		(dp_index == `IDX_SECONDS || dp_index == `IDX_MINUTES || dp_index == `IDX_HOURS);

	// ==========================================================
	// Time count and correction sequencing
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seconds <= 6'h00;
			minutes <= 6'h00;
			hours <= 5'h00;
			day_phase <= 1'b0;
			skip_cnt <= 4'h0;
			add_pend <= 4'h0;
			second_tick <= 1'b0;
		end else if (ce) begin
			second_tick <= tick;
			if (wr_time) begin
				// A software time write overrides any correction in progress
				case (dp_index)
				`IDX_SECONDS: seconds <= hwdata[5:0];
				`IDX_MINUTES: minutes <= hwdata[5:0];
				default: hours <= hwdata[4:0];
				endcase
				skip_cnt <= 4'h0;
				add_pend <= 4'h0;
			end else if (tick) begin
				if (skip_cnt != 4'h0) begin
					// Discarded tick: the time stands still
					skip_cnt <= skip_cnt - 4'h1;
				end else begin
					{hours, minutes, seconds} <= inc_time;
					if (corr_instant) begin
						if (trim_code[4])
							skip_cnt <= day_amount;
						else
							add_pend <= day_amount;
						day_phase <= ~day_phase;
					end
				end
			end else if (add_pend != 4'h0) begin
				// Extra seconds go in one per cycle, carrying like a normal tick
				{hours, minutes, seconds} <= inc_time;
				add_pend <= add_pend - 4'h1;
			end
		end
	end
endmodule

// [verification/rtc_cal_asserts.sv]
// Port-level checks for the one-second tick and daily trim block.
// Assumes a zero-wait-state bus and a crystal well below half the hclk rate.
`timescale 1ns/1ps
module rtc_cal_asserts (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire xtal_in,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire second_tick,
	input wire [5:0] seconds,
	input wire [5:0] minutes,
	input wire [4:0] hours
);
	reg wr_dp;
	reg rd_dp;
	reg xq;
	reg [3:0] quiet;
	// ==========================================================
	// Helpers
	// Software writes move the time, so their data-phase edges are exempt
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_dp <= 1'h0;
			rd_dp <= 1'h0;
			xq <= 1'h0;
			quiet <= 4'h0;
		end else begin
			wr_dp <= ce & hready & hsel & htrans[1] & hwrite;
			rd_dp <= ce & hready & hsel & htrans[1] & !hwrite;
			xq <= xtal_in;
			quiet <= (xq != xtal_in) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_tick_once;
		second_tick && ce |=> !second_tick;
	endproperty
	a_tick_once: assert property (p_tick_once) else $error("tick too long");
	property p_tick_gap;
		second_tick && ce |=> !second_tick [*7];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
	property p_no_xtal;
		quiet >= 4'hc |-> !second_tick;
	endproperty
	a_no_xtal: assert property (p_no_xtal) else $error("tick without crystal");
	property p_step;
		$changed(seconds) && !$past(wr_dp) |->
			seconds == (($past(seconds) == 6'h3b) ? 6'h00 : $past(seconds) + 6'h01);
	endproperty
	a_step: assert property (p_step) else $error("seconds jumped");
	property p_add_midnight;
		$changed(seconds) && !second_tick && !$past(wr_dp) |-> hours == 5'h00 && minutes == 6'h00;
	endproperty
	a_add_midnight: assert property (p_add_midnight) else $error("add off midnight");
	property p_add_bound;
		$changed(seconds) && !second_tick && !$past(wr_dp) |-> seconds > 6'h1e && seconds < 6'h27;
	endproperty
	a_add_bound: assert property (p_add_bound) else $error("add out of range");
	property p_skip_at_30;
		second_tick && $stable(seconds) && !$past(wr_dp) |->
			hours == 5'h00 && minutes == 6'h00 && seconds == 6'h1e;
	endproperty
	a_skip_at_30: assert property (p_skip_at_30) else $error("tick lost");
	property p_read_upper;
		rd_dp |-> hrdata[31:8] == 24'h000000;
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("upper read bits set");
endmodule
bind rtc_one_hz_calibration rtc_cal_asserts rtc_cal_asserts_i (.hclk(hclk), .hresetn(hresetn),
	.ce(ce), .xtal_in(xtal_in), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .second_tick(second_tick), .seconds(seconds), .minutes(minutes),
	.hours(hours));

// [verification/tb.sv]
// Self-checking bench for the one-second tick and daily trim block.
// Assumes a zero-wait-state slave; the crystal rising edge comes every 8 hclk.
`timescale 1ns/1ps
`include "rtc_cal_defs.vh"
module tb;
	reg hclk = 1'h0;
	reg hresetn = 1'h0;
	reg xtal_in = 1'h0;
	reg run = 1'h0;
	reg ce = 1'h1;
	reg [1:0] xc = 2'h0;
	reg hsel = 1'h0;
	reg [19:0] haddr = 20'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'h0;
	reg [31:0] hwdata = 32'h0;
	reg rd_dp = 1'h0;
	reg [31:0] e;
	wire hreadyout, hresp, second_tick;
	wire [31:0] hrdata;
	wire [5:0] seconds, minutes;
	wire [4:0] hours;
	logic [31:0] expq[$];
	integer error_cnt = 0, check_count = 0, cyc = 0, seed = 38241, ph = 0, i, k;
	integer codes[8] = '{-5, -5, -5, 3, 3, 0, -16, 15};
	rtc_one_hz_calibration rtc_one_hz_calibration_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.xtal_in(xtal_in), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .second_tick(second_tick), .seconds(seconds), .minutes(minutes),
		.hours(hours));
	always #20 hclk = ~hclk;
	// With one count per second, a second lasts five crystal periods: 40 hclk
	always @(posedge hclk) begin
		xc <= xc + 2'h1;
		if (run && xc == 2'h3) xtal_in <= ~xtal_in;
		cyc = cyc + 1;
		if (cyc == 20000) begin
			$display("wrong value at %0t: timeout", $time);
			error_cnt = error_cnt + 1;
			report_and_stop;
		end
	end
	// ==========================================================
	// Read-data monitor
	always @(posedge hclk) begin
		if (rd_dp && hreadyout === 1'h1) begin
			e = expq.pop_front();
			check_count = check_count + 1;
			if (hrdata !== e) begin
				$display("wrong value at %0t: read %h expected %h", $time, hrdata, e);
				error_cnt = error_cnt + 1;
			end
			if (hresp !== 1'h0) begin
				$display("wrong value at %0t: response not okay", $time);
				error_cnt = error_cnt + 1;
			end
		end
	end
	// ==========================================================
	// Bus and scenario tasks; for reads d is the expected data
	task bus(input [15:0] idx, input w, input [31:0] d);
		begin
			hsel <= 1'h1;
			haddr <= {2'h0, idx, 2'h0};
			htrans <= 2'h2;
			hwrite <= w;
			@(posedge hclk);
			while (hreadyout !== 1'h1) @(posedge hclk);
			hsel <= 1'h0;
			htrans <= 2'h0;
			hwdata <= d;
			rd_dp <= !w;
			if (!w) expq.push_back(d);
			@(posedge hclk);
			while (hreadyout !== 1'h1) @(posedge hclk);
			rd_dp <= 1'h0;
		end
	endtask
	task day(input integer c, input integer hr);
		integer n, a, p, r;
		begin
			r = $random(seed);
			bus(`IDX_DAILY_RATE_TRIM, 1'h1, {r[31:8], r[7:5], c[4:0]});
			bus(`IDX_DAILY_RATE_TRIM, 1'h0, {24'h0, r[7:5], c[4:0]});
			bus(`IDX_HOURS, 1'h1, hr);
			bus(`IDX_MINUTES, 1'h1, 32'h0);
			bus(`IDX_SECONDS, 1'h1, 32'h1d);
			n = (c < 0) ? -c : c;
			a = (hr != 0) ? 0 : (ph ? (n + 1) / 2 : n / 2);
			p = (c > 0) ? a : 0;
			if (hr == 0) ph = 1 - ph;
			for (i = 0; i < 200 && seconds !== 6'h1e; i++) @(posedge hclk);
			// Status two cycles after the trigger: add pending only while seconds remain
			bus(`IDX_CAL_STATUS, 1'h0, {29'h0, c > 0 && a > 1, c < 0 && a > 0, ph[0]});
			repeat (((c < 0) ? a * 40 : 0) + 20) @(posedge hclk);
			bus(`IDX_SECONDS, 1'h0, 30 + p);
			repeat (38) @(posedge hclk);
			bus(`IDX_SECONDS, 1'h0, 31 + p);
		end
	endtask
	task report_and_stop;
		begin
			if (error_cnt == 0 && check_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		bus(`IDX_DIV_BYTE0, 1'h0, 32'h85);
		bus(`IDX_DIV_BYTE1, 1'h0, 32'hec);
		bus(`IDX_DIV_BYTE2, 1'h0, 32'h0a);
		bus(16'h9140, 1'h1, 32'h5a);
		bus(16'h9140, 1'h0, 32'h0);
		bus(`IDX_DIV_BYTE0, 1'h1, 32'h01);
		bus(`IDX_DIV_BYTE1, 1'h1, 32'h00);
		bus(`IDX_DIV_BYTE2, 1'h1, 32'h00);
		bus(`IDX_DIV_BYTE0, 1'h0, 32'h01);
		run <= 1'h1;
		for (k = 0; k < 8; k++) day(codes[k], 0);
		day(-3, 1);
		// Clock enable low: the bus stalls and the time count stands at 01:00:32
		while (second_tick !== 1'h1) @(posedge hclk);
		ce <= 1'h0;
		fork
			bus(`IDX_SECONDS, 1'h0, 32'h20);
			begin
				repeat (60) @(posedge hclk);
				ce <= 1'h1;
			end
		join
		repeat (20) @(posedge hclk);
		bus(`IDX_SECONDS, 1'h0, 32'h20);
		report_and_stop;
	end
endmodule
